// ### rtl/ccs_pkg.sv
// Constants, types and decode functions for the clock source select registers.
// Assumes byte-wide special function registers at 20-bit addresses.
`default_nettype none
package ccs_pkg;
    // Register addresses.
    localparam logic [19:0] FM_CLK_SEL_ADDR = 20'hf007a;
    localparam logic [19:0] FAST_DIV_ADDR = 20'hf00a8;
    localparam logic [19:0] SUBCLK_OPT_ADDR = 20'hf00f3;
    localparam logic [19:0] PLL_CTRL_ADDR = 20'hf02e5;
    localparam logic [19:0] MID_DIV_ADDR = 20'hf0df2;
    // Field positions.
    localparam int GATE_BIT = 7;
    localparam int LS_SEL_BIT = 4;
    localparam int PLL_RUN_BIT = 0;
    localparam int PLL_MULT_BIT = 1;
    localparam int PLL_REF_LSB = 2;
    localparam logic [7:0] SUBCLK_OPT_MASK = 8'h90;
    // Reset values.
    localparam logic [1:0] FM_CLK_SEL_RST = 2'h0;
    localparam logic [2:0] FAST_DIV_RST = 3'h0;
    localparam logic [7:0] SUBCLK_OPT_RST = 8'h00;
    localparam logic [1:0] PLL_REF_RST = 2'h0;
    localparam logic [1:0] MID_DIV_RST = 2'h0;
    // Special codes and the middle oscillator base frequency.
    localparam logic [1:0] PLL_REF_DIV6 = 2'h3;
    localparam logic [1:0] MID_DIV_BAD = 2'h3;
    localparam logic [15:0] MID_BASE_KHZ = 16'h0fa0;
    // Timing.
    localparam int SYS_CLK_NS = 100;
    localparam int PLL_LOCK_NS = 40000;
    localparam int PLL_LOCK_CYC = (PLL_LOCK_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam logic [1:0] OLD_CLKS = 2'h3;
    localparam logic [1:0] NEW_CLKS = 2'h3;

    typedef enum logic [1:0] {
        CCS_FM_HSYS = 2'h0,
        CCS_FM_MID = 2'h1,
        CCS_FM_FAST = 2'h2
    } ccs_fm_src_t;

    typedef enum logic [2:0] {
        CCS_ST_IDLE = 3'h1,
        CCS_ST_OLD = 3'h2,
        CCS_ST_NEW = 3'h4
    } ccs_seq_state_t;

    // Fast oscillator frequency in kHz for a code and range; zero when prohibited.
    function automatic logic [15:0] ccs_fast_khz(input logic range, input logic [2:0] code);
        logic [15:0] khz;
        khz = 16'h0000;
        case (code)
            3'h0: khz = range ? 16'h7d00 : 16'h5dc0;
            3'h1: khz = range ? 16'h3e80 : 16'h2ee0;
            3'h2: khz = range ? 16'h1f40 : 16'h1770;
            3'h3: khz = range ? 16'h0fa0 : 16'h0bb8;
            3'h4: khz = range ? 16'h07d0 : 16'h05dc;
            3'h5: khz = range ? 16'h03e8 : 16'h0000;
            default: khz = 16'h0000;
        endcase
        return khz;
    endfunction : ccs_fast_khz

    function automatic logic ccs_fast_ok(input logic range, input logic [2:0] code);
        return ccs_fast_khz(range, code) != 16'h0000;
    endfunction : ccs_fast_ok
endpackage : ccs_pkg
`default_nettype wire

// ### rtl/ccs_sw_if.sv
// Link between the register block and the fast divider switch sequencer.
// Assumes both ends run on sys_clk.
`default_nettype none
interface ccs_sw_if;
    logic req;
    logic preset;
    logic [2:0] code;
    logic busy;
    logic hold;
    logic [2:0] active_code;
    modport ctrl (output req, output preset, output code, input busy, input hold,
        input active_code);
    modport seq (input req, input preset, input code, output busy, output hold,
        output active_code);
endinterface : ccs_sw_if
`default_nettype wire

// ### rtl/ccs_div_seq.sv
// Sequencer that switches the fast oscillator divider code.
// Assumes fih_tick pulses once per fast oscillator clock, synchronous to sys_clk.
`default_nettype none
module ccs_div_seq
    import ccs_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Fast oscillator clock edges.
    input wire logic fih_tick,
    // Register block side.
    ccs_sw_if.seq sw
);
    ccs_seq_state_t state_q;
    logic [1:0] cnt_q;
    logic [2:0] pend_q;
    logic hold_q;
    logic busy_q;
    logic [2:0] active_q;

    assign sw.hold = hold_q;
    assign sw.busy = busy_q;
    assign sw.active_code = active_q;

    // Old frequency runs three ticks, then the clock is held three new ticks.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q <= CCS_ST_IDLE;
            cnt_q <= 2'h0;
            pend_q <= FAST_DIV_RST;
            hold_q <= 1'b0;
            busy_q <= 1'b0;
            active_q <= FAST_DIV_RST;
        end else if (sw.preset) begin
            active_q <= sw.code;
        end else begin
            case (state_q)
                CCS_ST_IDLE: begin
                    if (sw.req) begin
                        pend_q <= sw.code;
                        cnt_q <= 2'h0;
                        busy_q <= 1'b1;
                        state_q <= CCS_ST_OLD;
                    end
                end
                CCS_ST_OLD: begin
                    if (fih_tick) begin
                        cnt_q <= cnt_q + 2'h1;
                        if (cnt_q == OLD_CLKS - 2'h1) begin
                            cnt_q <= 2'h0;
                            hold_q <= 1'b1;
                            active_q <= pend_q;
                            state_q <= CCS_ST_NEW;
                        end
                    end
                end
                CCS_ST_NEW: begin
                    if (fih_tick) begin
                        cnt_q <= cnt_q + 2'h1;
                        if (cnt_q == NEW_CLKS - 2'h1) begin
                            cnt_q <= 2'h0;
                            hold_q <= 1'b0;
                            busy_q <= 1'b0;
                            state_q <= CCS_ST_IDLE;
                        end
                    end
                end
                default: begin
                    hold_q <= 1'b0;
                    busy_q <= 1'b0;
                    state_q <= CCS_ST_IDLE;
                end
            endcase
        end
    end
endmodule : ccs_div_seq
`default_nettype wire

// ### rtl/ccs_regs.sv
// Clock source select registers: sub clock gating, low-speed source,
// fast and middle oscillator dividers, frequency meter source and PLL control.
// Assumes a byte-wide SFR port and status inputs synchronous to sys_clk.
//
// Functional notes
// - Gate bit set, CPU on sub clock, STOP or HALT: ungated peripherals lose sub clock.
// - Gate bit clear: sub clock keeps reaching peripherals in STOP or HALT.
// - Gate bit set with sub clock as subsystem source stops subsystem clock.
// - Low-speed select clear: timer group, meter trigger, buzzer use the sub clock.
// - Low-speed select set: timer group uses low-speed oscillator, buzzer output inhibited.
// - Setting low-speed select starts the low-speed on-chip oscillator.
// - Low-speed select set makes LCD internal boost unavailable.
// - Low-speed select change applies only while all fed peripherals are stopped; oscillator run and LCD boost availability follow the bit at once.
// - Fast divider comes from the boot option frequency field after reset.
// - Fast divider code maps to frequency by range bit; other codes prohibited.
// - Divider change: three old clocks, then hold three new clocks.
// - Middle divider codes give 4, 2, 1 MHz; code three prohibited.
// - Meter count clock: high-speed system, middle oscillator, or fast oscillator.
// - PLL reference divider code three divides fast oscillator by six.
// - PLL enable stops or runs the PLL; lock needs forty microseconds.
// - PLL multiplier value one gives multiply sixteen then divide two.
`default_nettype none
module ccs_regs (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Special function register port.
    input wire logic [19:0] sfr_addr,
    input wire logic sfr_wr_en,
    input wire logic sfr_rd_en,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Boot option byte fields.
    input wire logic [2:0] opt_freq_field,
    input wire logic fast_osc_range_bit,
    // Operating state of the surrounding clock system.
    input wire logic cpu_on_subclk,
    input wire logic cpu_on_fast_osc,
    input wire logic stop_mode,
    input wire logic halt_mode,
    input wire logic subsystem_source_select,
    input wire logic lowspeed_users_idle,
    input wire logic fih_tick,
    // Sub clock and low-speed source controls.
    output logic periph_subclk_en,
    output logic subsys_clk_run,
    output logic lowspeed_use_losc,
    output logic fm_trigger_use_losc,
    output logic buzzer_clock_out_pin_inhibit,
    output logic losc_run,
    output logic lcd_boost_avail,
    // Fast and middle oscillator frequencies.
    output logic [15:0] fih_freq_khz,
    output logic cpu_clk_hold,
    output logic fih_switch_busy,
    output logic [15:0] mid_onchip_osc_clock_khz,
    // Frequency meter count source.
    output ccs_pkg::ccs_fm_src_t fm_count_src,
    // PLL controls.
    output logic pll_ref_div6,
    output logic pll_run,
    output logic pll_locked,
    output logic pll_mult_x8
);
    import ccs_pkg::*;

    ccs_sw_if sw ();

    ccs_div_seq u_seq (
        .sys_clk(sys_clk),
        .reset(reset),
        .fih_tick(fih_tick),
        .sw(sw.seq)
    );

    // Register storage.
    logic gate_q;
    logic ls_sel_q;
    logic ls_eff_q;
    logic [2:0] fast_div_q;
    logic range_q;
    logic boot_done_q;
    logic [1:0] mid_div_q;
    logic [1:0] fm_sel_q;
    logic [1:0] pll_ref_q;
    logic pll_mult_q;
    logic pll_run_q;
    logic [9:0] lock_cnt_q;
    logic req_q;

    // Output flops.
    logic [7:0] sfr_rdata_q;
    logic periph_subclk_en_q;
    logic subsys_clk_run_q;
    logic lowspeed_use_losc_q;
    logic fm_trigger_use_losc_q;
    logic buzzer_inhibit_q;
    logic losc_run_q;
    logic lcd_boost_avail_q;
    logic [15:0] fih_freq_khz_q;
    logic [15:0] mid_khz_q;
    ccs_fm_src_t fm_src_q;
    logic pll_locked_q;

    // Write decode.
    logic wr_subclk;
    logic wr_fast;
    logic wr_mid;
    logic wr_fm;
    logic wr_pll;
    logic fast_wr_ok;
    logic [1:0] pll_ref_wr;
    logic pll_mult_wr;

    assign wr_subclk = sfr_wr_en && (sfr_addr == SUBCLK_OPT_ADDR);
    assign wr_fast = sfr_wr_en && (sfr_addr == FAST_DIV_ADDR);
    assign wr_mid = sfr_wr_en && (sfr_addr == MID_DIV_ADDR);
    assign wr_fm = sfr_wr_en && (sfr_addr == FM_CLK_SEL_ADDR);
    assign wr_pll = sfr_wr_en && (sfr_addr == PLL_CTRL_ADDR);
    assign fast_wr_ok = cpu_on_fast_osc && !sw.busy && boot_done_q &&
        ccs_fast_ok(range_q, sfr_wdata[2:0]);
    assign pll_ref_wr = sfr_wdata[PLL_REF_LSB+1:PLL_REF_LSB];
    assign pll_mult_wr = sfr_wdata[PLL_MULT_BIT];

    assign sw.code = boot_done_q ? sfr_wdata[2:0] : opt_freq_field;
    assign sw.preset = !boot_done_q;
    assign sw.req = req_q;

    // Sub clock option register; only the gate and low-speed bits are stored.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            gate_q <= SUBCLK_OPT_RST[GATE_BIT];
            ls_sel_q <= SUBCLK_OPT_RST[LS_SEL_BIT];
        end else if (wr_subclk) begin
            gate_q <= sfr_wdata[GATE_BIT];
            ls_sel_q <= sfr_wdata[LS_SEL_BIT];
        end
    end

    // Low-speed selection reaches the peripherals only while they are all stopped.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ls_eff_q <= SUBCLK_OPT_RST[LS_SEL_BIT];
        end else if (lowspeed_users_idle) begin
            ls_eff_q <= ls_sel_q;
        end
    end

    // Sub clock delivery in low-power states.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            periph_subclk_en_q <= 1'b1;
            subsys_clk_run_q <= 1'b1;
        end else begin
            periph_subclk_en_q <= !(gate_q && cpu_on_subclk && (stop_mode || halt_mode));
            subsys_clk_run_q <= !(gate_q && !subsystem_source_select);
        end
    end

    // Low-speed source effects.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            lowspeed_use_losc_q <= 1'b0;
            fm_trigger_use_losc_q <= 1'b0;
            buzzer_inhibit_q <= 1'b0;
            losc_run_q <= 1'b0;
            lcd_boost_avail_q <= 1'b1;
        end else begin
            lowspeed_use_losc_q <= ls_eff_q;
            fm_trigger_use_losc_q <= ls_eff_q;
            buzzer_inhibit_q <= ls_eff_q;
            losc_run_q <= ls_sel_q;
            lcd_boost_avail_q <= !ls_sel_q;
        end
    end

    // Boot load of the fast divider and range, one cycle after reset release.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            boot_done_q <= 1'b0;
            range_q <= 1'b0;
        end else if (!boot_done_q) begin
            boot_done_q <= 1'b1;
            range_q <= fast_osc_range_bit;
        end
    end

    // Fast divider register; prohibited codes and illegal moments are refused.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            fast_div_q <= FAST_DIV_RST;
            req_q <= 1'b0;
        end else if (!boot_done_q) begin
            fast_div_q <= opt_freq_field;
            req_q <= 1'b0;
        end else begin
            req_q <= wr_fast && fast_wr_ok;
            if (wr_fast && fast_wr_ok) begin
                fast_div_q <= sfr_wdata[2:0];
            end
        end
    end

    // Fast oscillator frequency follows the code the sequencer has applied.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            fih_freq_khz_q <= 16'h0000;
        end else begin
            fih_freq_khz_q <= ccs_fast_khz(range_q, sw.active_code);
        end
    end

    // Middle oscillator divider.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mid_div_q <= MID_DIV_RST;
        end else if (wr_mid && (sfr_wdata[1:0] != MID_DIV_BAD)) begin
            mid_div_q <= sfr_wdata[1:0];
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mid_khz_q <= MID_BASE_KHZ;
        end else begin
            mid_khz_q <= MID_BASE_KHZ >> mid_div_q;
        end
    end

    // Frequency meter count clock select.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            fm_sel_q <= FM_CLK_SEL_RST;
        end else if (wr_fm) begin
            fm_sel_q <= sfr_wdata[1:0];
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            fm_src_q <= CCS_FM_HSYS;
        end else if (fm_sel_q[1]) begin
            fm_src_q <= CCS_FM_FAST;
        end else if (fm_sel_q[0]) begin
            fm_src_q <= CCS_FM_MID;
        end else begin
            fm_src_q <= CCS_FM_HSYS;
        end
    end

    // PLL control; only reference code three and multiplier value one are taken, so neither can be cleared by a write.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pll_ref_q <= PLL_REF_RST;
            pll_mult_q <= 1'b0;
            pll_run_q <= 1'b0;
        end else if (wr_pll) begin
            pll_run_q <= sfr_wdata[PLL_RUN_BIT];
            if (pll_ref_wr == PLL_REF_DIV6) begin
                pll_ref_q <= pll_ref_wr;
            end
            if (pll_mult_wr) begin
                pll_mult_q <= 1'b1;
            end
        end
    end

    // Lock timer: counts while the PLL runs, restarts when it stops.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            lock_cnt_q <= 10'h000;
            pll_locked_q <= 1'b0;
        end else if (!pll_run_q) begin
            lock_cnt_q <= 10'h000;
            pll_locked_q <= 1'b0;
        end else if (lock_cnt_q == 10'(PLL_LOCK_CYC - 1)) begin
            pll_locked_q <= 1'b1;
        end else begin
            lock_cnt_q <= lock_cnt_q + 10'h001;
        end
    end

    // Read data; reserved bits and unmapped addresses read zero.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sfr_rdata_q <= 8'h00;
        end else if (sfr_rd_en) begin
            case (sfr_addr)
                SUBCLK_OPT_ADDR: begin
                    sfr_rdata_q <= {gate_q, 2'h0, ls_sel_q, 4'h0} & SUBCLK_OPT_MASK;
                end
                FAST_DIV_ADDR: begin
                    sfr_rdata_q <= {5'h00, fast_div_q};
                end
                MID_DIV_ADDR: begin
                    sfr_rdata_q <= {6'h00, mid_div_q};
                end
                FM_CLK_SEL_ADDR: begin
                    sfr_rdata_q <= {6'h00, fm_sel_q};
                end
                PLL_CTRL_ADDR: begin
                    sfr_rdata_q <= {4'h0, pll_ref_q, pll_mult_q, pll_run_q};
                end
                default: begin
                    sfr_rdata_q <= 8'h00;
                end
            endcase
        end
    end

    // Outputs.
    assign sfr_rdata = sfr_rdata_q;
    assign periph_subclk_en = periph_subclk_en_q;
    assign subsys_clk_run = subsys_clk_run_q;
    assign lowspeed_use_losc = lowspeed_use_losc_q;
    assign fm_trigger_use_losc = fm_trigger_use_losc_q;
    assign buzzer_clock_out_pin_inhibit = buzzer_inhibit_q;
    assign losc_run = losc_run_q;
    assign lcd_boost_avail = lcd_boost_avail_q;
    assign fih_freq_khz = fih_freq_khz_q;
    assign cpu_clk_hold = sw.hold;
    assign fih_switch_busy = sw.busy;
    assign mid_onchip_osc_clock_khz = mid_khz_q;
    assign fm_count_src = fm_src_q;
    assign pll_ref_div6 = (pll_ref_q == PLL_REF_DIV6);
    assign pll_run = pll_run_q;
    assign pll_locked = pll_locked_q;
    assign pll_mult_x8 = pll_mult_q;
endmodule : ccs_regs
`default_nettype wire

// ### test/ccs_regs_assertions.sv
// Concurrent checks for the clock source select register block.
// Assumes it is bound to ccs_regs and sees only that module's ports.
`default_nettype none
module ccs_regs_chk (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Register port.
    input wire logic [19:0] sfr_addr,
    input wire logic sfr_wr_en,
    input wire logic sfr_rd_en,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // Operating state.
    input wire logic cpu_on_subclk,
    input wire logic stop_mode,
    input wire logic halt_mode,
    input wire logic subsystem_source_select,
    input wire logic lowspeed_users_idle,
    // Watched outputs.
    input wire logic periph_subclk_en,
    input wire logic subsys_clk_run,
    input wire logic lowspeed_use_losc,
    input wire logic fm_trigger_use_losc,
    input wire logic buzzer_clock_out_pin_inhibit,
    input wire logic losc_run,
    input wire logic lcd_boost_avail,
    input wire logic [15:0] fih_freq_khz,
    input wire logic cpu_clk_hold,
    input wire logic fih_switch_busy,
    input wire logic [15:0] mid_onchip_osc_clock_khz,
    input wire logic pll_run,
    input wire logic pll_locked
);
    timeunit 1ns;
    timeprecision 1ns;
    import ccs_pkg::*;
    logic gate_q;
    logic ls_q;
    logic lp;
    logic sg;
    logic [1:0] age_q;
    logic [9:0] run_q;
    assign lp = gate_q && cpu_on_subclk && (stop_mode || halt_mode);
    assign sg = gate_q && !subsystem_source_select;
    // Mirror of the stored sub clock option bits.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            gate_q <= 1'b0;
            ls_q <= 1'b0;
        end else if (sfr_wr_en && sfr_addr == SUBCLK_OPT_ADDR) begin
            gate_q <= sfr_wdata[GATE_BIT];
            ls_q <= sfr_wdata[LS_SEL_BIT];
        end
    end
    // Cycles since reset release, saturating.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end
    // Cycles the PLL has been running, saturating.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset || !pll_run) begin
            run_q <= 10'h000;
        end else if (run_q != 10'h3ff) begin
            run_q <= run_q + 10'h001;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    a_gate_periph: assert property ($stable(lp) [*3] |-> periph_subclk_en == !lp)
        else $error("Peripheral sub clock enable disagrees with gating.");
    a_gate_subsys: assert property ($stable(sg) [*3] |-> subsys_clk_run == !sg)
        else $error("Subsystem clock run disagrees with gating.");
    a_losc_boost: assert property ($stable(ls_q) [*3] |-> losc_run == ls_q
        && lcd_boost_avail == !ls_q)
        else $error("Low-speed oscillator or boost state is wrong.");
    a_ls_follow: assert property ((lowspeed_users_idle && $stable(ls_q)) [*3] |->
        lowspeed_use_losc == ls_q && fm_trigger_use_losc == ls_q
        && buzzer_clock_out_pin_inhibit == ls_q)
        else $error("Low-speed clock selections do not follow the select bit.");
    a_ls_idle_only: assert property ($changed(lowspeed_use_losc) |->
        $past(lowspeed_users_idle) || $past(lowspeed_users_idle, 2))
        else $error("Low-speed selection changed while users were running.");
    a_rd_unused: assert property ($past(sfr_rd_en && sfr_addr == SUBCLK_OPT_ADDR) |->
        (sfr_rdata & ~SUBCLK_OPT_MASK) == 8'h00)
        else $error("Unused sub clock option bits read as one.");
    a_freq_switch: assert property (age_q == 2'h3 && $changed(fih_freq_khz) |-> fih_switch_busy)
        else $error("Fast frequency changed outside a switch.");
    a_hold_busy: assert property (cpu_clk_hold |-> fih_switch_busy)
        else $error("Clock hold outside a divider switch.");
    a_mid_legal: assert property (mid_onchip_osc_clock_khz inside {16'h0fa0, 16'h07d0, 16'h03e8})
        else $error("Middle oscillator frequency is not a legal value.");
    a_pll_lock: assert property ($rose(pll_locked) |-> run_q >= 10'h18e && run_q <= 10'h192)
        else $error("PLL lock did not follow the lock wait.");
    a_pll_stop: assert property (pll_locked |-> pll_run || $past(pll_run))
        else $error("PLL lock held after the PLL stopped.");
endmodule : ccs_regs_chk
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the clock source select register block.
// Assumes ccs_pkg and ccs_regs are compiled first.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ccs_pkg::*;
    typedef struct {
        logic [19:0] a;
        logic [7:0] w;
        logic [7:0] r;
        logic [15:0] o;
        logic k;
    } ccs_tb_row_t;
    logic sys_clk, reset, sfr_wr_en, sfr_rd_en, fast_osc_range_bit, cpu_on_subclk;
    logic cpu_on_fast_osc, stop_mode, halt_mode, subsystem_source_select;
    logic lowspeed_users_idle, fih_tick, periph_subclk_en, subsys_clk_run, lowspeed_use_losc;
    logic fm_trigger_use_losc, buzzer_clock_out_pin_inhibit, losc_run, lcd_boost_avail;
    logic cpu_clk_hold, fih_switch_busy, pll_ref_div6, pll_run, pll_locked, pll_mult_x8;
    logic [19:0] sfr_addr;
    logic [7:0] sfr_wdata, sfr_rdata, rb, st;
    logic [2:0] opt_freq_field;
    logic [15:0] fih_freq_khz, mid_onchip_osc_clock_khz;
    ccs_fm_src_t fm_count_src;
    int err_count = 0;
    int checks = 0;
    int n;
    ccs_tb_row_t rows [9] = '{
        '{FM_CLK_SEL_ADDR, 8'h02, 8'h02, 16'h0002, 1'b0},
        '{FM_CLK_SEL_ADDR, 8'h03, 8'h03, 16'h0002, 1'b0},
        '{FM_CLK_SEL_ADDR, 8'h01, 8'h01, 16'h0001, 1'b0},
        '{FM_CLK_SEL_ADDR, 8'h00, 8'h00, 16'h0000, 1'b0},
        '{MID_DIV_ADDR, 8'h01, 8'h01, 16'h07d0, 1'b1},
        '{MID_DIV_ADDR, 8'h02, 8'h02, 16'h03e8, 1'b1},
        '{MID_DIV_ADDR, 8'h03, 8'h02, 16'h03e8, 1'b1},
        '{MID_DIV_ADDR, 8'h00, 8'h00, 16'h0fa0, 1'b1},
        '{20'hf0000, 8'hff, 8'h00, 16'h0fa0, 1'b1}};
    localparam logic [19:0] ZA [5] = '{FM_CLK_SEL_ADDR, SUBCLK_OPT_ADDR, PLL_CTRL_ADDR,
        MID_DIV_ADDR, 20'hf0000};
    assign st = {periph_subclk_en, subsys_clk_run, losc_run, lcd_boost_avail, lowspeed_use_losc,
        buzzer_clock_out_pin_inhibit, fm_trigger_use_losc, pll_locked};
    ccs_regs dut (.*);
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic tally_and_finish;
        if (err_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int c);
        repeat (c) @(negedge sys_clk);
    endtask : cyc
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr_en = 1'b1;
        cyc(1);
        sfr_wr_en = 1'b0;
    endtask : wr
    task automatic rd(input logic [19:0] a, output logic [7:0] d);
        sfr_addr = a;
        sfr_rd_en = 1'b1;
        cyc(1);
        sfr_rd_en = 1'b0;
        d = sfr_rdata;
    endtask : rd
    task automatic tick(input int c);
        repeat (c) begin
            fih_tick = 1'b1;
            cyc(1);
            fih_tick = 1'b0;
            cyc(1);
        end
    endtask : tick
    task automatic do_reset;
        reset = 1'b1;
        cyc(8);
        reset = 1'b0;
        cyc(3);
    endtask : do_reset
    task automatic sw(input logic [7:0] code, input logic [15:0] old, input logic [15:0] nw);
        int i;
        logic hs;
        i = 0;
        hs = 1'b0;
        wr(FAST_DIV_ADDR, code);
        tick(2);
        chk(fih_freq_khz, old);
        while (fih_switch_busy === 1'b1 && i < 20) begin
            hs = hs | cpu_clk_hold;
            tick(1);
            i++;
        end
        if (i == 20) begin
            err_count++;
            tally_and_finish();
        end
        chk(16'(hs), 16'h0001);
        chk(fih_freq_khz, nw);
    endtask : sw
    initial begin
        {sfr_wr_en, sfr_rd_en, fast_osc_range_bit, cpu_on_subclk, stop_mode, halt_mode} = 6'h00;
        {subsystem_source_select, lowspeed_users_idle, fih_tick} = 3'h0;
        cpu_on_fast_osc = 1'b1;
        sfr_addr = 20'h00000;
        sfr_wdata = 8'h00;
        opt_freq_field = 3'h1;
        do_reset();
        for (int i = 0; i < 9; i++) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rb);
            chk(16'(rb), 16'(rows[i].r));
            chk(rows[i].k ? mid_onchip_osc_clock_khz : 16'(fm_count_src), rows[i].o);
        end
        sw(8'h02, 16'h2ee0, 16'h1770);
        wr(FAST_DIV_ADDR, 8'h05);
        cyc(3);
        chk(fih_freq_khz, 16'h1770);
        cpu_on_fast_osc = 1'b0;
        wr(FAST_DIV_ADDR, 8'h00);
        cyc(3);
        rd(FAST_DIV_ADDR, rb);
        chk(16'(rb), 16'h0002);
        cpu_on_fast_osc = 1'b1;
        wr(SUBCLK_OPT_ADDR, 8'h80);
        cpu_on_subclk = 1'b1;
        halt_mode = 1'b1;
        cyc(4);
        chk(16'(st), 16'h0010);
        halt_mode = 1'b0;
        stop_mode = 1'b1;
        subsystem_source_select = 1'b1;
        cyc(4);
        chk(16'(st), 16'h0050);
        stop_mode = 1'b0;
        cyc(4);
        chk(16'(st), 16'h00d0);
        wr(SUBCLK_OPT_ADDR, 8'h00);
        stop_mode = 1'b1;
        subsystem_source_select = 1'b0;
        cyc(4);
        chk(16'(st), 16'h00d0);
        stop_mode = 1'b0;
        wr(SUBCLK_OPT_ADDR, 8'h10);
        cyc(4);
        chk(16'(st), 16'h00e0);
        lowspeed_users_idle = 1'b1;
        cyc(4);
        chk(16'(st), 16'h00ee);
        wr(SUBCLK_OPT_ADDR, 8'h6f);
        rd(SUBCLK_OPT_ADDR, rb);
        chk(16'(rb), 16'h0000);
        cyc(4);
        chk(16'(st), 16'h00d0);
        lowspeed_users_idle = 1'b0;
        wr(PLL_CTRL_ADDR, 8'h06);
        rd(PLL_CTRL_ADDR, rb);
        chk(16'(rb), 16'h0002);
        chk(16'({pll_ref_div6, pll_mult_x8, pll_run}), 16'h0002);
        wr(PLL_CTRL_ADDR, 8'h0d);
        rd(PLL_CTRL_ADDR, rb);
        chk(16'(rb), 16'h000f);
        chk(16'({pll_ref_div6, pll_mult_x8, pll_run}), 16'h0007);
        n = 0;
        while (pll_locked !== 1'b1 && n < 500) begin
            cyc(1);
            n++;
        end
        chk(16'(n > 394 && n < 403), 16'h0001);
        wr(PLL_CTRL_ADDR, 8'h0c);
        cyc(2);
        chk(16'({pll_ref_div6, pll_mult_x8, pll_run, pll_locked}), 16'h000c);
        opt_freq_field = 3'h5;
        fast_osc_range_bit = 1'b1;
        do_reset();
        chk(fih_freq_khz, 16'h03e8);
        chk(16'(st), 16'h00d0);
        chk(mid_onchip_osc_clock_khz, 16'h0fa0);
        for (int i = 0; i < 5; i++) begin
            rd(ZA[i], rb);
            chk(16'(rb), 16'h0000);
        end
        sw(8'h00, 16'h03e8, 16'h7d00);
        tally_and_finish();
    end
endmodule : tb_top
bind ccs_regs ccs_regs_chk u_chk (.*);
`default_nettype wire
